// File: rtl/e3fo_top.sv
// Contract
// - Frame is 1536 bits, 12 overhead
// - Transmit alignment pattern in first ten bits
// - Receiver hunts pattern to gain, keep sync
// - Overhead: alarm, national, optional BIP-4 bits
// - Frame counter wraps once per frame
// - Receive fault sets alarm from next frame
// - Alarm held until fault clears, then zero
// - With BIP-4, alarm also carries block errors
// - National bit carries PMDL or alternative link
`timescale 1ns/10ps
`default_nettype none
module e3fo_top (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire e3fo_pkg::e3fo_reg_req_t reg_req,
  output logic [7:0]                   reg_rdata,
  output logic [1:0]                   timing_reference_choice,
  output logic                         g751_selected,
  input  wire e3fo_pkg::e3fo_ovh_src_t ovh_src,
  input  wire logic                    tx_payload,
  output logic                         tx_line,
  output logic                         tx_ovh_ind,
  output logic                         tx_frame_end,
  input  wire logic                    rx_line,
  input  wire logic                    rx_los,
  input  wire logic                    rx_ais,
  input  wire logic                    rx_block_error,
  output logic                         rx_in_frame,
  output logic                         rx_alarm_bit,
  output logic                         rx_national_bit
);
  import e3fo_pkg::*;

  e3fo_state_t s_q;
  e3fo_state_t s_d;
  logic        rx_bit;
  logic        fas_match;
  logic        mode_ok;
  logic        fault;
  logic        tx_bit;
  e3fo_cnt_t   tx_next;
  e3fo_cnt_t   rx_next;

  e3fo_fas_detect u_fas (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .line_in    (rx_line),
    .bit_en     (s_q.bit_en),
    .newest_bit (rx_bit),
    .fas_match  (fas_match)
  );

  always_comb begin
    s_d     = s_q;
    mode_ok = !s_q.opmode[LTS_BIT] && !s_q.opmode[FMT_BIT];
    fault   = s_q.los_sync[1] || s_q.ais_sync[1] || (s_q.rx_state != E3FO_SYNC);
    tx_next = (s_q.tx_cnt == e3fo_cnt_t'(FRAME_BITS - 1)) ? '0 : s_q.tx_cnt + 11'h001;
    rx_next = (s_q.rx_cnt == e3fo_cnt_t'(FRAME_BITS - 1)) ? '0 : s_q.rx_cnt + 11'h001;

    s_d.los_sync  = {s_q.los_sync[0], rx_los};
    s_d.ais_sync  = {s_q.ais_sync[0], rx_ais};
    s_d.febe_sync = {s_q.febe_sync[0], rx_block_error};

    // Divider producing the bit-rate enable; also freezes the transmit and receive framing while another format is chosen.
    s_d.bit_en   = 1'b0;
    s_d.bit_seen = s_q.bit_en;
    if (!mode_ok || s_q.div_cnt == 8'(BIT_DIV - 1)) begin
      s_d.div_cnt = 8'h00;
      s_d.bit_en  = mode_ok;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
    end

    if (reg_req.wr && reg_req.addr == OPMODE_ADDR) begin
      s_d.opmode = reg_req.wdata;
    end
    if (reg_req.rd) begin
      s_d.rdata = (reg_req.addr == OPMODE_ADDR) ? s_q.opmode : 8'h00;
    end

    // Transmit bit selection by frame position.
    if (s_q.tx_cnt < e3fo_cnt_t'(FAS_LEN)) begin
      tx_bit = FAS_PATTERN[4'(FAS_LEN - 1) - s_q.tx_cnt[3:0]];
    end else if (s_q.tx_cnt == e3fo_cnt_t'(A_POS)) begin
      tx_bit = s_q.alarm;
    end else if (s_q.tx_cnt == e3fo_cnt_t'(N_POS)) begin
      tx_bit = ovh_src.alt_link_select ? ovh_src.alt_link_bit : ovh_src.pmdl_bit;
    end else if (ovh_src.bip4_enable && s_q.tx_cnt >= e3fo_cnt_t'(BIP_POS)) begin
      tx_bit = s_q.bip_hold[s_q.tx_cnt[1:0]];
    end else begin
      tx_bit = tx_payload;
    end

    if (s_q.bit_en) begin
      s_d.tx_cnt       = tx_next;
      s_d.tx_line      = tx_bit;
      s_d.tx_frame_end = (s_q.tx_cnt == e3fo_cnt_t'(FRAME_BITS - 1));
      // The alignment pattern, alarm and national bits fill the first twelve positions of every frame.
      s_d.tx_ovh_ind   = (tx_next < e3fo_cnt_t'(OVH_BITS))
                         || (ovh_src.bip4_enable && tx_next >= e3fo_cnt_t'(BIP_POS));
      if (s_q.tx_cnt >= e3fo_cnt_t'(OVH_BITS) && s_q.tx_cnt < e3fo_cnt_t'(BIP_POS)) begin
        s_d.bip_acc[s_q.tx_cnt[1:0]] = s_q.bip_acc[s_q.tx_cnt[1:0]] ^ tx_bit;
      end
      if (s_q.tx_cnt == e3fo_cnt_t'(FRAME_BITS - 1)) begin
        // Sampling at the boundary keeps the alarm steady for a whole frame.
        s_d.alarm    = fault || (ovh_src.bip4_enable && s_q.febe_sync[1]);
        s_d.bip_hold = s_q.bip_acc;
        s_d.bip_acc  = 4'h0;
      end
    end else begin
      s_d.tx_frame_end = 1'b0;
      s_d.tx_ovh_ind   = s_q.tx_ovh_ind && mode_ok;
    end

    // Receive framer runs one cycle after the detector has shifted the new bit in.
    if (s_q.bit_seen) begin
      unique case (s_q.rx_state)
        E3FO_HUNT: begin
          if (fas_match) begin
            s_d.rx_cnt   = e3fo_cnt_t'(FAS_LEN - 1);
            s_d.rx_state = E3FO_VERIFY;
          end
        end
        E3FO_VERIFY, E3FO_SYNC: begin
          s_d.rx_cnt = rx_next;
          if (rx_next == e3fo_cnt_t'(FAS_LEN - 1)) begin
            if (fas_match) begin
              s_d.rx_state = E3FO_SYNC;
              s_d.miss     = 3'h0;
            end else if (s_q.rx_state == E3FO_VERIFY
                         || s_q.miss == 3'(OOF_MISS_LIMIT - 1)) begin
              s_d.rx_state = E3FO_HUNT;
              s_d.miss     = 3'h0;
            end else begin
              s_d.miss = s_q.miss + 3'h1;
            end
          end
          if (s_q.rx_state == E3FO_SYNC && rx_next == e3fo_cnt_t'(A_POS)) begin
            s_d.rx_a = rx_bit;
          end
          if (s_q.rx_state == E3FO_SYNC && rx_next == e3fo_cnt_t'(N_POS)) begin
            s_d.rx_n = rx_bit;
          end
        end
      endcase
    end

    // Both flags are registered from next-state values so they move in the same cycle as what they describe.
    s_d.g751     = !s_d.opmode[LTS_BIT] && !s_d.opmode[FMT_BIT];
    s_d.in_frame = (s_d.rx_state == E3FO_SYNC);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q          <= '0;
      s_q.opmode   <= OPMODE_RESET;
      s_q.rx_state <= E3FO_HUNT;
      s_q.g751     <= !OPMODE_RESET[LTS_BIT] && !OPMODE_RESET[FMT_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata               = s_q.rdata;
  assign timing_reference_choice = s_q.opmode[TREF_MSB:TREF_LSB];
  assign g751_selected           = s_q.g751;
  assign tx_line                 = s_q.tx_line;
  assign tx_ovh_ind              = s_q.tx_ovh_ind;
  assign tx_frame_end            = s_q.tx_frame_end;
  assign rx_in_frame             = s_q.in_frame;
  assign rx_alarm_bit            = s_q.rx_a;
  assign rx_national_bit         = s_q.rx_n;

endmodule // e3fo_top
`default_nettype wire

// File: rtl/e3fo_pkg.sv
`default_nettype none
package e3fo_pkg;

  localparam int unsigned FRAME_BITS    = 1536;
  localparam int unsigned OVH_BITS      = 12;
  localparam int unsigned PAYLOAD_BITS  = 1524;
  localparam int unsigned FAS_LEN       = 10;
  localparam logic [9:0]  FAS_PATTERN   = 10'h3D0;
  localparam int unsigned A_POS         = 10;
  localparam int unsigned N_POS         = 11;
  localparam int unsigned BIP_LEN       = 4;
  localparam int unsigned BIP_POS       = FRAME_BITS - BIP_LEN;
  localparam int unsigned FRAME_RATE_HZ = 22375;
  localparam int unsigned LINE_RATE_BPS = FRAME_RATE_HZ * FRAME_BITS;
  localparam int unsigned MCLK_HZ       = 10000000;
  // The system clock is slower than the line rate, so the bit enable fires every cycle at most.
  localparam int unsigned BIT_DIV       = (MCLK_HZ / LINE_RATE_BPS) < 1 ? 1 : (MCLK_HZ / LINE_RATE_BPS);
  localparam int unsigned OOF_MISS_LIMIT = 4;

  localparam logic [7:0]  OPMODE_ADDR   = 8'h00;
  localparam logic [7:0]  OPMODE_RESET  = 8'h00;
  localparam int unsigned LTS_BIT       = 6;
  localparam int unsigned FMT_BIT       = 2;
  localparam int unsigned TREF_LSB      = 0;
  localparam int unsigned TREF_MSB      = 1;

  typedef logic [10:0] e3fo_cnt_t;

  typedef enum logic [1:0] {
    E3FO_HUNT,
    E3FO_VERIFY,
    E3FO_SYNC
  } e3fo_rx_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } e3fo_reg_req_t;

  typedef struct packed {
    logic pmdl_bit;
    logic alt_link_bit;
    logic alt_link_select;
    logic bip4_enable;
  } e3fo_ovh_src_t;

  typedef struct packed {
    logic [7:0]     div_cnt;
    logic           bit_en;
    logic           bit_seen;
    logic [7:0]     opmode;
    logic [7:0]     rdata;
    e3fo_cnt_t      tx_cnt;
    logic           tx_line;
    logic           tx_ovh_ind;
    logic           tx_frame_end;
    logic           alarm;
    logic [3:0]     bip_acc;
    logic [3:0]     bip_hold;
    logic [1:0]     los_sync;
    logic [1:0]     ais_sync;
    logic [1:0]     febe_sync;
    e3fo_rx_state_t rx_state;
    e3fo_cnt_t      rx_cnt;
    logic [2:0]     miss;
    logic           rx_a;
    logic           rx_n;
    logic           g751;
    logic           in_frame;
  } e3fo_state_t;

endpackage
`default_nettype wire

// File: rtl/e3fo_fas_detect.sv
`timescale 1ns/10ps
`default_nettype none
module e3fo_fas_detect (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic line_in,
  input  wire logic bit_en,
  output logic      newest_bit,
  output logic      fas_match
);
  import e3fo_pkg::*;

  logic [FAS_LEN-1:0] shift_q;
  logic [FAS_LEN-1:0] shift_d;

  // Both synchroniser stages live here; only the second stage is read.
  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d  = {sync_q[0], line_in};
    shift_d = shift_q;
    if (bit_en) begin
      shift_d = {shift_q[FAS_LEN-2:0], sync_q[1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift_q <= 10'h000;
      sync_q  <= 2'h0;
    end else begin
      shift_q <= shift_d;
      sync_q  <= sync_d;
    end
  end

  assign newest_bit = shift_q[0];
  assign fas_match  = (shift_q == FAS_PATTERN);

endmodule // e3fo_fas_detect
`default_nettype wire

// File: testbench/e3fo_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module e3fo_top_properties (
  input wire logic                    mclk,
  input wire logic                    reset_n,
  input wire e3fo_pkg::e3fo_reg_req_t reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    g751_selected,
  input wire e3fo_pkg::e3fo_ovh_src_t ovh_src,
  input wire logic                    tx_line,
  input wire logic                    tx_ovh_ind,
  input wire logic                    tx_frame_end,
  input wire logic                    rx_los,
  input wire logic                    rx_ais,
  input wire logic                    rx_block_error,
  input wire logic                    rx_in_frame,
  input wire logic                    rx_alarm_bit,
  input wire logic                    rx_national_bit
);
  import e3fo_pkg::*;
  logic [11:0] per_q;
  logic [11:0] low_q;
  logic        seen_q;
  logic        bip_ok_q;
  logic [5:0]  flt_q;
  logic [3:0]  bip_q;
  logic [3:0]  bip_hold_q;
  default clocking cb @(posedge mclk); endclocking
  // A frozen transmitter is not framing, so the stream checks rest while the mode is other than G.751.
  default disable iff (!reset_n || !g751_selected);
  always_ff @(posedge mclk) begin
    flt_q <= {flt_q[4:0], rx_los | rx_ais | !rx_in_frame | (ovh_src.bip4_enable & rx_block_error)};
    // The low-time count saturates so that a long hunt cannot wrap it to a small value.
    low_q <= (!reset_n || rx_in_frame) ? 12'h000 : low_q + {11'h000, low_q != 12'hFFF};
    seen_q <= reset_n && g751_selected && (seen_q || tx_frame_end);
    per_q <= (!reset_n || !g751_selected || tx_frame_end) ? 12'h001 : per_q + 12'h001;
    // Parity is only trusted once a whole frame has been counted from its first bit.
    bip_ok_q <= reset_n && g751_selected && (bip_ok_q || (seen_q && tx_frame_end));
    if (tx_frame_end) begin
      bip_q      <= 4'h0;
      bip_hold_q <= bip_q;
    end else if (per_q >= 12'h00D && per_q <= 12'h5FC) begin
      bip_q[per_q[1:0] - 2'h1] <= bip_q[per_q[1:0] - 2'h1] ^ tx_line;
    end
  end
  a_fas_pattern: assert property (tx_frame_end |=> tx_line [*4] ##1 !tx_line ##1 tx_line ##1 !tx_line [*4])
    else $error("alignment pattern wrong");
  a_frame_period: assert property (seen_q |-> tx_frame_end == (per_q == 12'h600))
    else $error("frame length wrong");
  a_ovh_warn: assert property (tx_frame_end |-> tx_ovh_ind ##1 tx_ovh_ind [*8] ##1 tx_ovh_ind [*3] ##1 !tx_ovh_ind)
    else $error("overhead warning wrong");
  a_alarm_set: assert property (tx_frame_end ##1 flt_q == 6'h3F |-> ##10 tx_line)
    else $error("alarm bit not set");
  a_alarm_clear: assert property (tx_frame_end ##1 flt_q == 6'h00 |-> ##10 !tx_line)
    else $error("alarm bit not cleared");
  a_national_bit: assert property (tx_frame_end ##11 $stable(ovh_src) ##1 $stable(ovh_src) |->
    tx_line == (ovh_src.alt_link_select ? ovh_src.alt_link_bit : ovh_src.pmdl_bit)) else $error("national bit wrong");
  a_bip_value: assert property (bip_ok_q && ovh_src.bip4_enable && $stable(ovh_src.bip4_enable) && per_q >= 12'h5FD
    |-> tx_line == bip_hold_q[per_q[1:0] - 2'h1]) else $error("parity bits wrong");
  a_rx_gain: assert property ($rose(rx_in_frame) |-> low_q >= 12'h600)
    else $error("sync gained too early");
  a_rx_hold: assert property (!rx_in_frame && !$past(rx_in_frame) && !$past(rx_in_frame, 2) |->
    $stable(rx_alarm_bit) && $stable(rx_national_bit)) else $error("overhead updated out of sync");
  a_mode_select: assert property (disable iff (!reset_n) reg_req.wr && reg_req.addr == OPMODE_ADDR |=>
    g751_selected == !($past(reg_req.wdata[6]) || $past(reg_req.wdata[2]))) else $error("mode select wrong");
  a_unmapped_read: assert property (disable iff (!reset_n) reg_req.rd && reg_req.addr != OPMODE_ADDR |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // e3fo_top_properties
bind e3fo_top e3fo_top_properties i_e3fo_top_properties (.mclk, .reset_n, .reg_req, .reg_rdata, .g751_selected,
  .ovh_src, .tx_line, .tx_ovh_ind, .tx_frame_end, .rx_los, .rx_ais, .rx_block_error, .rx_in_frame, .rx_alarm_bit,
  .rx_national_bit);
`default_nettype wire

// File: testbench/e3fo_liu_model.sv
`timescale 1ns/10ps
`default_nettype none
module e3fo_liu_model (
  input wire logic  mclk,
  input wire logic  tx_line,
  input wire logic  corrupt,
  output var logic  rx_line,
  output logic      far_fail
);
  import e3fo_pkg::*;
  logic [11:0] sh_q;
  logic [2:0]  run_q = 3'h0;
  always_ff @(posedge mclk) begin
    rx_line <= tx_line ^ corrupt;
    sh_q <= {sh_q[10:0], tx_line};
    // One set alarm bit alone is not a failure; the remote end waits for a run of frames.
    if (sh_q[11:2] == FAS_PATTERN) begin
      run_q <= !sh_q[1] ? 3'h0 : (run_q == 3'h7 ? run_q : run_q + 3'h1);
    end
  end
  assign far_fail = run_q >= 3'h3;
endmodule // e3fo_liu_model
`default_nettype wire

// File: testbench/e3fo_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module e3fo_top_tb;
  import e3fo_pkg::*;
  logic          mclk = 1'b0;
  logic          reset_n = 1'b0;
  logic          tx_payload = 1'b0;
  logic          rx_los = 1'b0;
  logic          rx_ais = 1'b0;
  logic          rx_block_error = 1'b0;
  logic          corrupt = 1'b0;
  e3fo_reg_req_t reg_req = '0;
  e3fo_ovh_src_t ovh_src = '0;
  logic [7:0]    reg_rdata;
  logic [1:0]    timing_reference_choice;
  logic          g751_selected, tx_line, tx_ovh_ind, tx_frame_end, rx_line;
  logic          rx_in_frame, rx_alarm_bit, rx_national_bit, far_fail;
  int            fails = 0;
  int            compares = 0;

  e3fo_top i_e3fo_top (.mclk, .reset_n, .reg_req, .reg_rdata, .timing_reference_choice, .g751_selected, .ovh_src,
    .tx_payload, .tx_line, .tx_ovh_ind, .tx_frame_end, .rx_line, .rx_los, .rx_ais, .rx_block_error, .rx_in_frame,
    .rx_alarm_bit, .rx_national_bit);
  e3fo_liu_model i_e3fo_liu_model (.mclk, .tx_line, .corrupt, .rx_line, .far_fail);

  initial forever #50 mclk = ~mclk;
  // A toggling payload can never mimic the alignment pattern, so the far end cannot false-lock.
  always @(negedge mclk) tx_payload <= ~tx_payload;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk) reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk) reg_req.rd = 1'b0;
    @(negedge mclk) chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic frames(input int n);
    repeat (n * FRAME_BITS) @(negedge mclk);
  endtask

  task automatic sync_wait;
    for (int i = 0; i < 4000 && rx_in_frame !== 1'b1; i++) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    chk("g751_selected", {7'h00, g751_selected}, 8'h01);
    rd(OPMODE_ADDR, OPMODE_RESET);
    rd(8'h05, 8'h00);
    wr(OPMODE_ADDR, 8'h44);
    chk("g751_selected", {7'h00, g751_selected}, 8'h00);
    rd(OPMODE_ADDR, 8'h44);
    wr(OPMODE_ADDR, 8'h03);
    rd(OPMODE_ADDR, 8'h03);
    chk("timing_reference_choice", {6'h00, timing_reference_choice}, 8'h03);
    chk("g751_selected", {7'h00, g751_selected}, 8'h01);
    sync_wait();
    chk("rx_in_frame", {7'h00, rx_in_frame}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      {rx_block_error, rx_ais, rx_los} = 3'h1 << k;
      ovh_src.bip4_enable = (k == 2);
      frames(5);
      chk("far_fail", {7'h00, far_fail}, 8'h01);
      {rx_block_error, rx_ais, rx_los} = 3'h0;
      frames(3);
      chk("far_fail", {7'h00, far_fail}, 8'h00);
      chk("rx_alarm_bit", {7'h00, rx_alarm_bit}, 8'h00);
    end
    ovh_src.pmdl_bit = 1'b1;
    frames(2);
    chk("rx_national_bit", {7'h00, rx_national_bit}, 8'h01);
    ovh_src.alt_link_select = 1'b1;
    frames(2);
    chk("rx_national_bit", {7'h00, rx_national_bit}, 8'h00);
    corrupt = 1'b1;
    // Four missed patterns, one frame to reach the boundary and three alarm frames need up to eight frames.
    frames(8);
    chk("rx_in_frame", {7'h00, rx_in_frame}, 8'h00);
    chk("far_fail", {7'h00, far_fail}, 8'h01);
    corrupt = 1'b0;
    sync_wait();
    chk("rx_in_frame", {7'h00, rx_in_frame}, 8'h01);
    report_and_stop();
  end
endmodule // e3fo_top_tb
`default_nettype wire
